// ==== src/cbc_capture_control.sv ====
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Upper two byte counters run only while wide counter A is off.
// - Lower two byte counters run only while wide counter B is off.
// - Each low-nibble enable bit turns its byte counter off or on.
// - With filtering on, an edge starts a counter for the chosen cycle count.
// - Filter emits a pulse only if the level after the delay has flipped.
// - Filter counter clears itself once the delay is done.
// - Delay select: bypass, 256, 512 or 1024 clock cycles.
// - Capture empties on read, or on a latch for channels 0-3; holding empties on read.
// - No-overwrite bit blocks event writes until the registers are empty.
// - System control takes one write in normal mode, any number otherwise.
// - Share bit lets lower channel x pin drive capture channel x+4 too.
// - Queue, flag mode, no-overwrite: first capture loads; second transfers and flags.
// - Flag mode in queue mode flags channels 0-3 only on holding loads.
// - Byte counter at FF wraps to 00, or stays at FF when saturating.
// - Buffer enable off disables holding registers; on, latch-or-queue picks style.
// - Force latch write in latch mode copies captures and counters to holding.
// - Latch-or-queue does nothing while buffering is off.
// - Queue pushes prior capture to holding; latch copies channels 0-3 on zero events.
module cbc_capture_control (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [7:0] PIN_IN,
    input wire logic [7:0] RISE_EN,
    input wire logic [7:0] FALL_EN,
    input wire logic NORMAL_MODE,
    input wire logic MODULUS_ZERO,
    input wire logic COUNT_ZERO_WRITE,
    input wire logic COUNT_ACCESS,
    input wire logic [7:0] CAP_READ,
    input wire logic [7:0] HOLD_READ,
    output logic [7:0] CAP_LOAD,
    output logic [7:0] HOLD_LOAD,
    output logic [7:0] FLAG_SET,
    output logic ACC_LATCH,
    output logic [3:0] SMALL_ACC_ACTIVE,
    output logic [31:0] SMALL_ACC,
    output logic [31:0] SMALL_ACC_HOLD
);
    import cbc_pkg::*;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] lvl;
        logic [7:0] ovw;
        logic [7:0] sys;
        logic [7:0] accen;
        logic [7:0] aux;
        logic sys_locked;
        logic uf;
        logic [3:0] polf;
        logic [3:0] pol_seen;
        logic [7:0] cap_full;
        logic [7:0] hold_full;
        logic [7:0] cap_load;
        logic [7:0] hold_load;
        logic [7:0] flag_set;
        logic acc_latch;
        logic [3:0] act;
        logic [3:0][7:0] acc;
        logic [3:0][7:0] acc_hold;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic readyout;
        logic resp;
    } cbc_state_t;

    cbc_state_t s;
    cbc_state_t next_s;

    logic [7:0] filt_pulse;
    logic [7:0] filt_rise;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_filter
            cbc_edge_filter #(
                .CNT_W(CBC_FILTER_CNT_W)
            ) u_filter (
                .clk(CLK),
                .rst(SYS_RST),
                .delay_sel(cbc_delay_t'(s.aux[CBC_AUX_DELAY_LSB +: 2])),
                .level(s.lvl[gi]),
                .pulse(filt_pulse[gi]),
                .rise(filt_rise[gi])
            );
        end
    endgenerate

    function automatic logic [7:0] cbc_step(input logic [7:0] v, input logic sat);
        if (sat && v == CBC_ACC_FULL) begin
            return v;
        end
        return v + 8'h01;
    endfunction : cbc_step

    function automatic logic [7:0] cbc_read(input cbc_state_t st, input logic [7:0] idx);
        unique case (idx)
            CBC_IDX_FLAGS: return {st.uf, 3'h0, st.polf};
            CBC_IDX_ACC_EN: return {4'h0, st.accen[3:0]};
            CBC_IDX_OVERWRITE: return st.ovw;
            CBC_IDX_SYSCTL: return st.sys;
            CBC_IDX_AUX: return st.aux & CBC_AUX_MASK;
            default: return CBC_RESET_VALUE;
        endcase
    endfunction : cbc_read

    logic [7:0] edge_ok;
    logic [7:0] chan_ev;
    logic [7:0] chan_rise;
    logic buf_on;
    logic latch_mode;
    logic queue_mode;
    logic addr_ok;

    always_comb begin
        edge_ok = filt_pulse & ((filt_rise & RISE_EN) | (~filt_rise & FALL_EN));
        chan_ev[3:0] = edge_ok[3:0];
        chan_rise[3:0] = filt_rise[3:0];
        for (int y = 4; y < 8; y++) begin
            // Sharing replaces the upper pin; the upper filter is then unused
            if (s.sys[CBC_SYS_SHARE_LSB + y - 4]) begin
                chan_ev[y] = edge_ok[y - 4];
                chan_rise[y] = filt_rise[y - 4];
            end else begin
                chan_ev[y] = edge_ok[y];
                chan_rise[y] = filt_rise[y];
            end
        end
        buf_on = s.sys[CBC_SYS_BUFFER_ENABLE];
        latch_mode = buf_on && s.sys[CBC_SYS_LATCH_OR_QUEUE];
        queue_mode = buf_on && !s.sys[CBC_SYS_LATCH_OR_QUEUE];
        addr_ok = (HADDR[31:10] == 22'h0) && (HADDR[1:0] == 2'b00);
    end

    always_comb begin
        logic force_latch;
        logic latch_ev;
        logic [7:0] wdat;
        force_latch = 1'b0;
        latch_ev = 1'b0;
        wdat = HWDATA[7:0];
        next_s = s;
        next_s.cap_load = '0;
        next_s.hold_load = '0;
        next_s.flag_set = '0;
        next_s.acc_latch = 1'b0;
        next_s.readyout = 1'b1;
        next_s.resp = 1'b0;

        // Pin synchroniser; a change counts once stages two and three agree
        next_s.s1 = PIN_IN;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < 8; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.lvl[i] = s.s3[i];
            end
        end

        // Reads empty the registers; a same-cycle event below still wins
        next_s.cap_full = s.cap_full & ~CAP_READ;
        next_s.hold_full = s.hold_full & ~HOLD_READ;
        if (s.aux[CBC_AUX_FAST_CLEAR] && COUNT_ACCESS) begin
            next_s.uf = 1'b0;
        end

        // Data phase of a write
        if (s.wr_pend) begin
            next_s.wr_pend = 1'b0;
            unique case (s.wr_idx)
                CBC_IDX_FLAGS: begin
                    if (wdat[CBC_FLG_UNDERFLOW]) begin
                        next_s.uf = 1'b0;
                    end
                end
                CBC_IDX_ACC_EN: next_s.accen = {4'h0, wdat[3:0]};
                CBC_IDX_OVERWRITE: next_s.ovw = wdat;
                CBC_IDX_SYSCTL: begin
                    if (!NORMAL_MODE || !s.sys_locked) begin
                        next_s.sys = wdat;
                        next_s.sys_locked = NORMAL_MODE;
                    end
                end
                CBC_IDX_AUX: begin
                    next_s.aux = wdat & CBC_AUX_MASK;
                    force_latch = wdat[CBC_AUX_FORCE_LATCH];
                end
                default: ;
            endcase
        end

        // Address phase
        if (HSEL && HREADY && HTRANS == CBC_HTRANS_NONSEQ && HSIZE == CBC_HSIZE_WORD) begin
            if (HWRITE) begin
                next_s.wr_pend = addr_ok;
                next_s.wr_idx = HADDR[9:2];
            end else begin
                next_s.rdata = {24'h0, addr_ok ? cbc_read(s, HADDR[9:2]) : CBC_RESET_VALUE};
            end
        end

        // Byte counter enables with the wide counter exclusions
        next_s.act[3] = s.accen[3] && !s.aux[CBC_AUX_WIDE_A];
        next_s.act[2] = s.accen[2] && !s.aux[CBC_AUX_WIDE_A];
        next_s.act[1] = s.accen[1] && !s.aux[CBC_AUX_WIDE_B];
        next_s.act[0] = s.accen[0] && !s.aux[CBC_AUX_WIDE_B];

        // Latch events only act in latch mode with buffering on
        latch_ev = latch_mode && (MODULUS_ZERO || COUNT_ZERO_WRITE || force_latch);
        if (latch_ev) begin
            next_s.acc_latch = 1'b1;
            next_s.pol_seen = '0;
            for (int n = 0; n < 4; n++) begin
                next_s.acc_hold[n] = s.acc[n];
                next_s.acc[n] = CBC_ACC_ZERO;
                if (!s.ovw[n] || !next_s.hold_full[n]) begin
                    next_s.hold_load[n] = 1'b1;
                    next_s.hold_full[n] = 1'b1;
                    next_s.cap_full[n] = 1'b0;
                    if (s.sys[CBC_SYS_FLAGMODE] == 1'b0) begin
                        next_s.flag_set[n] = next_s.flag_set[n];
                    end
                end
            end
        end

        // Byte counters count their own pin's valid edges
        for (int n = 0; n < 4; n++) begin
            if (s.act[n] && edge_ok[n]) begin
                next_s.acc[n] = cbc_step(next_s.acc[n], s.sys[CBC_SYS_SATURATE]);
            end
        end

        // Capture events per channel
        for (int n = 0; n < 8; n++) begin
            if (chan_ev[n]) begin
                if (queue_mode && next_s.cap_full[n]) begin
                    // Transfer needs room in holding when no-overwrite is set
                    if (!s.ovw[n] || !next_s.hold_full[n]) begin
                        next_s.hold_load[n] = 1'b1;
                        next_s.hold_full[n] = 1'b1;
                        next_s.cap_load[n] = 1'b1;
                        next_s.cap_full[n] = 1'b1;
                        if (s.sys[CBC_SYS_FLAGMODE] && n < 4) begin
                            next_s.flag_set[n] = 1'b1;
                        end
                    end
                end else if (!s.ovw[n] || !next_s.cap_full[n]) begin
                    next_s.cap_load[n] = 1'b1;
                    next_s.cap_full[n] = 1'b1;
                end
                // Outside queue flag mode every valid edge flags the channel
                if (!(s.sys[CBC_SYS_FLAGMODE] && queue_mode) || n >= 4) begin
                    next_s.flag_set[n] = 1'b1;
                end
                if (n < 4 && !next_s.pol_seen[n] && next_s.cap_load[n]) begin
                    next_s.polf[n] = chan_rise[n];
                    next_s.pol_seen[n] = 1'b1;
                end
            end
        end

        // Hardware set beats a software clear in the same cycle
        if (MODULUS_ZERO) begin
            next_s.uf = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s <= '0;
            s.readyout <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        HRDATA = s.rdata;
        HREADYOUT = s.readyout;
        HRESP = s.resp;
        CAP_LOAD = s.cap_load;
        HOLD_LOAD = s.hold_load;
        FLAG_SET = s.flag_set;
        ACC_LATCH = s.acc_latch;
        SMALL_ACC_ACTIVE = s.act;
        SMALL_ACC = s.acc;
        SMALL_ACC_HOLD = s.acc_hold;
    end

endmodule : cbc_capture_control

`default_nettype wire

// ==== pkg/cbc_pkg.sv ====
package cbc_pkg;

    // Register indexes; the byte address is four times the index
    localparam logic [7:0] CBC_IDX_FLAGS = 8'hA7;
    localparam logic [7:0] CBC_IDX_ACC_EN = 8'hA8;
    localparam logic [7:0] CBC_IDX_OVERWRITE = 8'hAA;
    localparam logic [7:0] CBC_IDX_SYSCTL = 8'hAB;
    localparam logic [7:0] CBC_IDX_AUX = 8'hAC;

    localparam logic [7:0] CBC_RESET_VALUE = 8'h00;

    // Flags register layout
    localparam int CBC_FLG_UNDERFLOW = 7;

    // System control layout
    localparam int CBC_SYS_LATCH_OR_QUEUE = 0;
    localparam int CBC_SYS_BUFFER_ENABLE = 1;
    localparam int CBC_SYS_SATURATE = 2;
    localparam int CBC_SYS_FLAGMODE = 3;
    localparam int CBC_SYS_SHARE_LSB = 4;

    // Auxiliary control layout
    localparam int CBC_AUX_WIDE_A = 0;
    localparam int CBC_AUX_WIDE_B = 1;
    localparam int CBC_AUX_DELAY_LSB = 2;
    localparam int CBC_AUX_FAST_CLEAR = 4;
    localparam int CBC_AUX_FORCE_LATCH = 5;
    localparam logic [7:0] CBC_AUX_MASK = 8'h1F;

    // Filter delay selection
    typedef enum logic [1:0] {
        CBC_DLY_BYPASS = 2'b00,
        CBC_DLY_256 = 2'b01,
        CBC_DLY_512 = 2'b10,
        CBC_DLY_1024 = 2'b11
    } cbc_delay_t;

    localparam int CBC_DELAY_CYCLES_256 = 256;
    localparam int CBC_DELAY_CYCLES_512 = 512;
    localparam int CBC_DELAY_CYCLES_1024 = 1024;
    localparam int CBC_FILTER_CNT_W = 11;

    localparam logic [7:0] CBC_ACC_FULL = 8'hFF;
    localparam logic [7:0] CBC_ACC_ZERO = 8'h00;

    // AHB-Lite encodings
    localparam logic [1:0] CBC_HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] CBC_HSIZE_WORD = 3'b010;

endpackage : cbc_pkg

// ==== src/cbc_edge_filter.sv ====
`timescale 1ns/1ns
`default_nettype none

module cbc_edge_filter #(
    parameter int CNT_W = cbc_pkg::CBC_FILTER_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire cbc_pkg::cbc_delay_t delay_sel,
    input wire logic level,
    output logic pulse,
    output logic rise
);
    import cbc_pkg::*;

    if (CNT_W < 11) begin : g_check
        $error("cbc_edge_filter: CNT_W too small for 1024 cycles");
    end

    typedef struct packed {
        logic held;
        logic busy;
        logic [CNT_W-1:0] cnt;
        logic pulse;
        logic rise;
    } cbc_filter_t;

    cbc_filter_t s;
    cbc_filter_t next_s;

    function automatic logic [CNT_W-1:0] cbc_last(input cbc_delay_t sel);
        unique case (sel)
            CBC_DLY_256: return CNT_W'(CBC_DELAY_CYCLES_256 - 1);
            CBC_DLY_512: return CNT_W'(CBC_DELAY_CYCLES_512 - 1);
            CBC_DLY_1024: return CNT_W'(CBC_DELAY_CYCLES_1024 - 1);
            CBC_DLY_BYPASS: return '0;
        endcase
    endfunction : cbc_last

    always_comb begin
        next_s = s;
        next_s.pulse = 1'b0;
        if (delay_sel == CBC_DLY_BYPASS) begin
            next_s.busy = 1'b0;
            next_s.cnt = '0;
            if (level != s.held) begin
                next_s.held = level;
                next_s.pulse = 1'b1;
                next_s.rise = level;
            end
        end else if (!s.busy) begin
            if (level != s.held) begin
                next_s.busy = 1'b1;
                next_s.cnt = '0;
            end
        end else if (s.cnt == cbc_last(delay_sel)) begin
            next_s.busy = 1'b0;
            next_s.cnt = '0;
            // A pulse narrower than the delay leaves the level unchanged
            if (level != s.held) begin
                next_s.held = level;
                next_s.pulse = 1'b1;
                next_s.rise = level;
            end
        end else begin
            next_s.cnt = s.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pulse = s.pulse;
    assign rise = s.rise;

endmodule : cbc_edge_filter

`default_nettype wire

// ==== tb/cbc_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module cbc_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [7:0] CAP_LOAD,
    input wire logic [7:0] HOLD_LOAD,
    input wire logic [7:0] FLAG_SET,
    input wire logic ACC_LATCH,
    input wire logic [3:0] SMALL_ACC_ACTIVE,
    input wire logic [31:0] SMALL_ACC
);
    import cbc_pkg::*;
    logic take;
    logic bad;
    logic wr_d;
    logic [7:0] idx_d;
    logic [3:0] en_sh;
    logic [1:0] wide_sh;
    logic [1:0] quiet;
    assign take = HSEL && HREADY && HTRANS == CBC_HTRANS_NONSEQ && HSIZE == CBC_HSIZE_WORD;
    assign bad = HADDR[31:10] != 22'h0 || HADDR[1:0] != 2'h0 || !(HADDR[9:2] inside
        {CBC_IDX_FLAGS, CBC_IDX_ACC_EN, CBC_IDX_OVERWRITE, CBC_IDX_SYSCTL, CBC_IDX_AUX});
    // Shadow of the enable writes; judged only once it has stood three cycles
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_d <= 1'b0;
            idx_d <= 8'h00;
            en_sh <= 4'h0;
            wide_sh <= 2'h0;
            quiet <= 2'h0;
        end else begin
            wr_d <= take && HWRITE && !bad;
            idx_d <= HADDR[9:2];
            if (wr_d && idx_d == CBC_IDX_ACC_EN) en_sh <= HWDATA[3:0];
            if (wr_d && idx_d == CBC_IDX_AUX) wide_sh <= HWDATA[1:0];
            if (wr_d && (idx_d == CBC_IDX_ACC_EN || idx_d == CBC_IDX_AUX)) begin
                quiet <= 2'h0;
            end else if (quiet != 2'h3) begin
                quiet <= quiet + 2'h1;
            end
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    chk_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus slave stalled or errored");
    chk_rdata_high: assert property (HRDATA[31:8] == 24'h0)
        else $error("read data above register width");
    chk_unmapped_zero: assert property (take && !HWRITE && bad |=> HRDATA == 32'h0)
        else $error("unmapped read returned data");
    chk_upper_pair: assert property (quiet == 2'h3 && wide_sh[0] |-> !(|SMALL_ACC_ACTIVE[3:2]))
        else $error("upper byte counters on beside wide counter A");
    chk_lower_pair: assert property (quiet == 2'h3 && wide_sh[1] |-> !(|SMALL_ACC_ACTIVE[1:0]))
        else $error("lower byte counters on beside wide counter B");
    chk_enable_follow: assert property (quiet == 2'h3 |-> SMALL_ACC_ACTIVE ==
        (en_sh & ~{wide_sh[0], wide_sh[0], wide_sh[1], wide_sh[1]}))
        else $error("effective byte counter enables wrong");
    chk_upper_no_latch: assert property ((HOLD_LOAD[7:4] & ~CAP_LOAD[7:4]) == 4'h0)
        else $error("upper channel holding load without capture");
    chk_upper_flags: assert property ((CAP_LOAD[7:4] & ~FLAG_SET[7:4]) == 4'h0)
        else $error("upper channel capture without flag");
    chk_latch_clears: assert property (ACC_LATCH |-> ##[0:2] SMALL_ACC == 32'h0)
        else $error("byte counters not cleared by latch");
    chk_single_pulse: assert property (|CAP_LOAD |=> (CAP_LOAD & $past(CAP_LOAD)) == 8'h00)
        else $error("capture load longer than one cycle");
endmodule : cbc_checker
`default_nettype wire

// ==== tb/cbc_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cbc_pin_model (
    input wire logic CLK,
    output logic [7:0] PIN_IN
);
    initial PIN_IN = 8'h00;
    // Levels are held whole cycles; anything narrower the synchroniser would drop
    task automatic put(input int ch, input logic v, input int hold);
        @(posedge CLK);
        PIN_IN[ch] <= v;
        repeat (hold) @(posedge CLK);
    endtask : put
endmodule : cbc_pin_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import cbc_pkg::*;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic NORMAL_MODE = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = CBC_HSIZE_WORD;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [7:0] RISE_EN = 8'h01;
    logic [7:0] FALL_EN = 8'h00;
    logic [7:0] CAP_READ = 8'h00;
    logic [7:0] HOLD_READ = 8'h00;
    logic HREADYOUT, HRESP, ACC_LATCH;
    logic [3:0] SMALL_ACC_ACTIVE;
    logic [7:0] PIN_IN, CAP_LOAD, HOLD_LOAD, FLAG_SET, cl, hl, fl;
    logic [31:0] HRDATA, SMALL_ACC, SMALL_ACC_HOLD, rd;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int latches = 0;
    int n;
    int dly[4] = '{0, CBC_DELAY_CYCLES_256, CBC_DELAY_CYCLES_512, CBC_DELAY_CYCLES_1024};
    logic [7:0] idxs[6] = '{CBC_IDX_FLAGS, CBC_IDX_ACC_EN, CBC_IDX_OVERWRITE, CBC_IDX_SYSCTL,
        CBC_IDX_AUX, 8'hA9};
    wire HREADY = HREADYOUT;
    cbc_capture_control u_dut (.CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
        .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .PIN_IN, .RISE_EN, .FALL_EN,
        .NORMAL_MODE, .MODULUS_ZERO(ev[0]), .COUNT_ZERO_WRITE(ev[1]), .COUNT_ACCESS(ev[2]),
        .CAP_READ, .HOLD_READ, .CAP_LOAD, .HOLD_LOAD, .FLAG_SET, .ACC_LATCH,
        .SMALL_ACC_ACTIVE, .SMALL_ACC, .SMALL_ACC_HOLD);
    cbc_pin_model u_pins (.CLK, .PIN_IN);
    always #4 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (ACC_LATCH === 1'b1) latches <= latches + 1;
        if (cycles == 40000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HADDR <= {22'h0, idx, 2'h0};
        HTRANS <= CBC_HTRANS_NONSEQ;
        HWRITE <= wr;
        do @(posedge CLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, d};
        do @(posedge CLK); while (HREADY !== 1'b1);
        rd = HRDATA;
    endtask : bus
    task automatic capw(input int ch, input int lim);
        n = 0;
        while (n < lim && CAP_LOAD[ch] !== 1'b1) begin
            @(posedge CLK);
            n++;
        end
        cl = CAP_LOAD;
        hl = HOLD_LOAD;
        fl = FLAG_SET;
    endtask : capw
    task automatic rise(input int ch);
        u_pins.put(ch, 1'b1, 0);
        capw(ch, 50);
        u_pins.put(ch, 1'b0, 10);
    endtask : rise
    task automatic strobe(input logic [2:0] v);
        @(posedge CLK);
        ev <= v;
        @(posedge CLK);
        ev <= 3'h0;
        repeat (4) @(posedge CLK);
    endtask : strobe
    task automatic t_regs();
        foreach (idxs[i]) begin
            bus(1'b0, idxs[i], 8'h00);
            check(rd, 32'h0);
        end
        bus(1'b1, CBC_IDX_OVERWRITE, 8'h5A);
        bus(1'b1, 8'hA9, 8'hFF);
        bus(1'b0, CBC_IDX_OVERWRITE, 8'h00);
        check(rd, 32'h5A);
        bus(1'b0, 8'hA9, 8'h00);
        check(rd, 32'h0);
        bus(1'b1, CBC_IDX_OVERWRITE, 8'h00);
        $display("test registers done");
    endtask : t_regs
    task automatic t_acc();
        bus(1'b1, CBC_IDX_ACC_EN, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, CBC_IDX_AUX, 8'(i));
            repeat (3) @(posedge CLK);
            check(32'(SMALL_ACC_ACTIVE), 32'({~i[0], ~i[0], ~i[1], ~i[1]}));
        end
        bus(1'b1, CBC_IDX_AUX, 8'h00);
        bus(1'b1, CBC_IDX_ACC_EN, 8'h00);
        repeat (3) @(posedge CLK);
        check(32'(SMALL_ACC_ACTIVE), 32'h0);
        $display("test enables done");
    endtask : t_acc
    task automatic t_delay();
        int base;
        base = 0;
        for (int d = 0; d < 4; d++) begin
            bus(1'b1, CBC_IDX_AUX, 8'(d << 2));
            u_pins.put(0, 1'b1, 0);
            capw(0, 1200);
            if (d == 0) base = n;
            check(32'(n), 32'(base + dly[d]));
            check(32'({fl[0], hl[0]}), 32'h2);
            u_pins.put(0, 1'b0, 1100);
        end
        bus(1'b1, CBC_IDX_AUX, 8'h04);
        u_pins.put(0, 1'b1, 20);
        u_pins.put(0, 1'b0, 0);
        capw(0, 400);
        check(32'(n), 32'(400));
        u_pins.put(0, 1'b1, 0);
        capw(0, 1200);
        check(32'(n), 32'(base + dly[1]));
        u_pins.put(0, 1'b0, 1100);
        bus(1'b1, CBC_IDX_AUX, 8'h00);
        $display("test filter done");
    endtask : t_delay
    task automatic t_queue();
        // The filter test left channel 0 full; start from an empty capture
        CAP_READ <= 8'h01;
        bus(1'b1, CBC_IDX_OVERWRITE, 8'h01);
        bus(1'b1, CBC_IDX_SYSCTL, 8'h0A);
        CAP_READ <= 8'h00;
        rise(0);
        check(32'({n < 50, hl[0], fl[0]}), 32'h4);
        rise(0);
        check(32'({n < 50, hl[0], fl[0]}), 32'h7);
        rise(0);
        check(32'(n), 32'(50));
        @(posedge CLK);
        CAP_READ <= 8'h01;
        HOLD_READ <= 8'h01;
        @(posedge CLK);
        CAP_READ <= 8'h00;
        HOLD_READ <= 8'h00;
        rise(0);
        check(32'({n < 50, hl[0], fl[0]}), 32'h4);
        bus(1'b1, CBC_IDX_OVERWRITE, 8'h00);
        $display("test queue done");
    endtask : t_queue
    task automatic t_share();
        bus(1'b1, CBC_IDX_SYSCTL, 8'h10);
        RISE_EN <= 8'h11;
        rise(0);
        check({24'h0, cl}, 32'h11);
        bus(1'b1, CBC_IDX_SYSCTL, 8'h00);
        rise(0);
        check({24'h0, cl}, 32'h01);
        RISE_EN <= 8'h01;
        $display("test share done");
    endtask : t_share
    task automatic edges(input int k);
        repeat (k) begin
            u_pins.put(0, 1'b1, 4);
            u_pins.put(0, 1'b0, 4);
        end
        repeat (8) @(posedge CLK);
    endtask : edges
    task automatic t_sat();
        bus(1'b1, CBC_IDX_ACC_EN, 8'h01);
        edges(255);
        check(SMALL_ACC, 32'hFF);
        edges(1);
        check(SMALL_ACC, 32'h0);
        bus(1'b1, CBC_IDX_SYSCTL, 8'h04);
        edges(256);
        check(SMALL_ACC, 32'hFF);
        $display("test counters done");
    endtask : t_sat
    task automatic t_latch();
        int k;
        k = latches;
        bus(1'b1, CBC_IDX_SYSCTL, 8'h01);
        bus(1'b1, CBC_IDX_AUX, 8'h20);
        repeat (4) @(posedge CLK);
        check(32'(latches - k), 32'h0);
        bus(1'b1, CBC_IDX_SYSCTL, 8'h03);
        bus(1'b1, CBC_IDX_AUX, 8'h20);
        repeat (4) @(posedge CLK);
        check(32'(latches - k), 32'h1);
        check(SMALL_ACC_HOLD, 32'hFF);
        check(SMALL_ACC, 32'h0);
        strobe(3'h1);
        check(32'(latches - k), 32'h2);
        bus(1'b1, CBC_IDX_FLAGS, 8'h00);
        bus(1'b0, CBC_IDX_FLAGS, 8'h00);
        // Channel 0 polarity stays rising from the filter test; latches do not clear it
        check(rd, 32'h81);
        bus(1'b1, CBC_IDX_FLAGS, 8'h80);
        bus(1'b0, CBC_IDX_FLAGS, 8'h00);
        check(rd, 32'h01);
        strobe(3'h1);
        bus(1'b1, CBC_IDX_AUX, 8'h10);
        strobe(3'h4);
        bus(1'b0, CBC_IDX_FLAGS, 8'h00);
        check(rd, 32'h01);
        strobe(3'h2);
        check(32'(latches - k), 32'h4);
        FALL_EN <= 8'h02;
        RISE_EN <= 8'h04;
        u_pins.put(1, 1'b1, 10);
        u_pins.put(1, 1'b0, 10);
        u_pins.put(2, 1'b1, 10);
        u_pins.put(2, 1'b0, 10);
        bus(1'b0, CBC_IDX_FLAGS, 8'h00);
        check(rd, 32'h05);
        strobe(3'h1);
        FALL_EN <= 8'h04;
        RISE_EN <= 8'h00;
        u_pins.put(2, 1'b1, 10);
        u_pins.put(2, 1'b0, 10);
        bus(1'b0, CBC_IDX_FLAGS, 8'h00);
        check(rd, 32'h81);
        $display("test latch done");
    endtask : t_latch
    task automatic t_once();
        @(posedge CLK);
        SYS_RST <= 1'b1;
        NORMAL_MODE <= 1'b1;
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        bus(1'b1, CBC_IDX_SYSCTL, 8'h0A);
        bus(1'b1, CBC_IDX_SYSCTL, 8'h05);
        bus(1'b0, CBC_IDX_SYSCTL, 8'h00);
        check(rd, 32'h0A);
        NORMAL_MODE <= 1'b0;
        bus(1'b1, CBC_IDX_SYSCTL, 8'h05);
        bus(1'b0, CBC_IDX_SYSCTL, 8'h00);
        check(rd, 32'h05);
        $display("test mode done");
    endtask : t_once
    initial begin
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_regs();
        t_acc();
        t_delay();
        t_queue();
        t_share();
        t_sat();
        t_latch();
        t_once();
        end_sim();
    end
endmodule : testbench
bind cbc_capture_control cbc_checker u_chk (.CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .CAP_LOAD, .HOLD_LOAD, .FLAG_SET,
    .ACC_LATCH, .SMALL_ACC_ACTIVE, .SMALL_ACC);
`default_nettype wire
